/* File: hw/reg_bank_pkg.sv */
package reg_bank_pkg;
   // Register offsets (8-bit address byte)
   localparam logic [7:0] ADDR_NO_OPERATION = 8'h00;
   localparam logic [7:0] ADDR_GLOBAL_RESET = 8'h01;
   localparam logic [7:0] ADDR_RESET_AND_CLEAR_CONFIG = 8'h02;
   localparam logic [7:0] ADDR_CHANNEL_AND_FEATURE_SELECT = 8'h03;
   localparam logic [7:0] ADDR_CHANNEL_OUTPUT_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_CHANNEL_OUTPUT_CODE = 8'h05;
   localparam logic [7:0] ADDR_CONVERTER_SELECT = 8'h06;
   localparam logic [7:0] ADDR_CONVERTER_CONFIG = 8'h07;
   localparam logic [7:0] ADDR_CALIBRATION_ENABLE = 8'h08;
   localparam logic [7:0] ADDR_GAIN_TRIM = 8'h09;
   localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h0A;
   localparam logic [7:0] ADDR_FAULT_STATUS = 8'h0B;
   localparam logic [7:0] ADDR_FAULT_MASK = 8'h0C;
   localparam logic [7:0] ADDR_FAULT_RESPONSE = 8'h0D;
   localparam logic [7:0] ADDR_FAULT_OUTPUT_CODE = 8'h0E;
   localparam logic [7:0] ADDR_WATCHDOG_SERVICE = 8'h10;
   localparam logic [7:0] ADDR_PART_IDENTITY = 8'h11;
   // Field positions
   localparam int RESET_REQ_BIT = 0;
   localparam int USER_CHECK_BIT = 0;
   localparam int POWER_OFF_STATE_BIT = 1;
   localparam int SOFTWARE_CLEAR_BIT = 2;
   localparam int TRANSPARENT_BIT = 3;
   localparam int REF_ENABLE_BIT = 4;
   localparam int CLEAR_PERMIT_LSB = 9;
   localparam int CLEAR_LEVEL_LSB = 9;
   localparam int SELECT_OUTPUT_LSB = 5;
   localparam int STATUS_CLEAR_STATE_BIT = 12;
   localparam int STATUS_WATCHDOG_BIT = 11;
   localparam int STATUS_SUPPLY_GOOD_LSB = 7;
   localparam int STATUS_USER_ECHO_BIT = 6;
   localparam int STATUS_FRAME_ERR_BIT = 5;
   localparam int STATUS_THERMAL_BIT = 4;
   localparam int STATUS_LOAD_ERR_LSB = 0;
   localparam int RANGE_LSB = 0;
   // Writable-bit masks and the part identity read mask; unused bits read as zero
   localparam logic [15:0] MASK_GLOBAL_RESET = 16'h0001;
   localparam logic [15:0] MASK_RESET_CONFIG = 16'h1E1F;
   localparam logic [15:0] MASK_SELECT = 16'h1FFF;
   localparam logic [15:0] MASK_CONVERTER_SELECT = 16'h000F;
   localparam logic [15:0] MASK_CONVERTER_CONFIG = 16'h0FFF;
   localparam logic [15:0] MASK_CAL_ENABLE = 16'h0001;
   localparam logic [15:0] MASK_FAULT_MASK = 16'h083F;
   localparam logic [15:0] MASK_FAULT_RESPONSE = 16'h00FF;
   localparam logic [15:0] MASK_FAULT_CODE = 16'hFFC0;
   localparam logic [15:0] MASK_PART_ID = 16'h0007;
   // Reset values and clear codes
   localparam logic [15:0] RESET_ZERO = 16'h0000;
   localparam logic [15:0] RESET_GAIN_TRIM = 16'h8000;
   localparam logic [15:0] CODE_ZERO_SCALE = 16'h0000;
   localparam logic [15:0] CODE_MID_SCALE = 16'h8000;
   // Voltage output gain encodings
   typedef enum logic [2:0]
   {
      GAIN_X1 = 3'b000,
      GAIN_X2 = 3'b001,
      GAIN_X4 = 3'b010,
      GAIN_X1P2 = 3'b011,
      GAIN_X2P4 = 3'b100,
      GAIN_X4P8 = 3'b101
   } gain_sel_t;
   // Sequencer states
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_RESET = 2'b01,
      ST_CLEAR = 2'b10
   } seq_state_t;
endpackage : reg_bank_pkg

/* File: hw/channel_store.sv */
`timescale 1ns/1ps
`default_nettype none
// Per-channel register copy; written when its channel is selected
module channel_store #(
   parameter int WIDTH = 16,
   parameter logic [15:0] RESET_VALUE = 16'h0000
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_soft_rst,
   input wire logic i_wr,
   input wire logic [WIDTH-1:0] i_wdata,
   input wire logic i_clr,
   input wire logic [WIDTH-1:0] i_clr_value,
   output logic [WIDTH-1:0] o_value
);
   logic [WIDTH-1:0] value_reg;
   logic [WIDTH-1:0] value_next;

   // Reset beats clear, clear beats write
   assign value_next = i_soft_rst ? RESET_VALUE[WIDTH-1:0] :
                       i_clr ? i_clr_value :
                       i_wr ? i_wdata : value_reg;

   // Storage
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         value_reg <= RESET_VALUE[WIDTH-1:0];
      else if (i_ce)
         value_reg <= value_next;
   end

   assign o_value = value_reg;
endmodule : channel_store
`default_nettype wire

/* File: hw/gain_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// Maps the four-bit range field onto a voltage output gain
module gain_decode (
   input wire logic [3:0] i_range,
   output reg_bank_pkg::gain_sel_t o_gain,
   output logic o_valid
);
   always_comb
   begin
      o_valid = 1'b1;
      case (i_range)
         4'h0: o_gain = reg_bank_pkg::GAIN_X1;
         4'h1, 4'h2: o_gain = reg_bank_pkg::GAIN_X2;
         4'h3: o_gain = reg_bank_pkg::GAIN_X4;
         4'h8: o_gain = reg_bank_pkg::GAIN_X1P2;
         4'h9, 4'hA: o_gain = reg_bank_pkg::GAIN_X2P4;
         4'hB: o_gain = reg_bank_pkg::GAIN_X4P8;
         default:
         begin
            o_gain = reg_bank_pkg::GAIN_X1;
            o_valid = 1'b0;
         end
      endcase
   end
endmodule : gain_decode
`default_nettype wire

/* File: hw/quad_dac_control_register_bank.sv */
// Operation
// - Reset bit restores defaults except power-off state
// - Reset request bit self-clears after reset
// - Bits 12:9 permit clear per channel
// - Clear trigger clears permitted channels' codes
// - Clear trigger bit returns to zero itself
// - Power-off state bit sets output parking
// - Bit 4 enables internal reference
// - Bit 3 selects transparent serial mode
// - Range field selects voltage output gain
// - Address zero is write-only no-operation
// - Output code and trims are 16 bits
// - Status register flag layout
// - Clear level select picks zero or mid
`timescale 1ns/1ps
`default_nettype none
module quad_dac_control_register_bank #(
   parameter int CHANNELS = 4,
   parameter logic [15:0] PART_ID_CODE = 16'h0005 // Arbitrary identity value
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_hw_clear,
   input wire logic i_watchdog_timeout,
   input wire logic [3:0] i_supply_good,
   input wire logic i_frame_check_error,
   input wire logic i_thermal_alarm,
   input wire logic [3:0] i_load_error,
   output logic [15:0] o_rdata,
   output logic o_rd_valid,
   output logic o_watchdog_service,
   output logic o_power_off_output_state,
   output logic o_ref_enable,
   output logic o_transparent_serial_mode,
   output logic o_serial_out_disable,
   output logic o_frame_check_enable,
   output logic o_clear_state,
   output logic [63:0] o_output_code,
   output logic [11:0] o_gain_sel,
   output logic [3:0] o_range_valid
);
   reg_bank_pkg::seq_state_t state_reg;
   reg_bank_pkg::seq_state_t state_next;
   logic [15:0] global_reset_reg;
   logic [15:0] reset_config_reg;
   logic [15:0] select_reg;
   logic [15:0] conv_select_reg;
   logic [15:0] status_reg;
   logic [15:0] fault_mask_reg;
   logic [15:0] fault_response_reg;
   logic poc_reg;
   logic [15:0] rdata_reg;
   logic rd_valid_reg;
   logic wd_service_reg;
   logic soft_rst;
   logic clear_go;
   logic [3:0] ch_sel;
   logic [3:0] conv_sel;
   logic [3:0] clr_permit;
   logic [3:0] clr_level;
   logic [15:0] rd_mux;
   logic [15:0] ch_rd;
   logic wr_reset;
   logic wr_rcfg;
   logic wr_sel;
   logic wr_csel;
   logic wr_mask;
   logic wr_resp;
   logic wr_wd;
   logic [15:0] cfg_q [CHANNELS];
   logic [15:0] code_q [CHANNELS];
   logic [15:0] cconf_q [CHANNELS];
   logic [15:0] cal_q [CHANNELS];
   logic [15:0] gain_q [CHANNELS];
   logic [15:0] off_q [CHANNELS];
   logic [15:0] fcode_q [CHANNELS];

   // Address decode; address zero matches no register
   assign wr_reset = i_wr_en && (i_addr == reg_bank_pkg::ADDR_GLOBAL_RESET);
   assign wr_rcfg = i_wr_en && (i_addr == reg_bank_pkg::ADDR_RESET_AND_CLEAR_CONFIG);
   assign wr_sel = i_wr_en && (i_addr == reg_bank_pkg::ADDR_CHANNEL_AND_FEATURE_SELECT);
   assign wr_csel = i_wr_en && (i_addr == reg_bank_pkg::ADDR_CONVERTER_SELECT);
   assign wr_mask = i_wr_en && (i_addr == reg_bank_pkg::ADDR_FAULT_MASK);
   assign wr_resp = i_wr_en && (i_addr == reg_bank_pkg::ADDR_FAULT_RESPONSE);
   assign wr_wd = i_wr_en && (i_addr == reg_bank_pkg::ADDR_WATCHDOG_SERVICE);

   // Field extraction
   assign ch_sel = select_reg[reg_bank_pkg::SELECT_OUTPUT_LSB +: 4];
   assign conv_sel = conv_select_reg[3:0];
   assign clr_permit = reset_config_reg[reg_bank_pkg::CLEAR_PERMIT_LSB +: 4];
   assign clr_level = select_reg[reg_bank_pkg::CLEAR_LEVEL_LSB +: 4];

   // Sequencer drives one-cycle reset and clear actions
   assign soft_rst = (state_reg == reg_bank_pkg::ST_RESET);
   assign clear_go = (state_reg == reg_bank_pkg::ST_CLEAR) || i_hw_clear;

   always_comb
   begin
      case (state_reg)
         reg_bank_pkg::ST_IDLE:
         begin
            if (global_reset_reg[reg_bank_pkg::RESET_REQ_BIT])
               state_next = reg_bank_pkg::ST_RESET;
            else if (reset_config_reg[reg_bank_pkg::SOFTWARE_CLEAR_BIT])
               state_next = reg_bank_pkg::ST_CLEAR;
            else
               state_next = reg_bank_pkg::ST_IDLE;
         end
         reg_bank_pkg::ST_RESET: state_next = reg_bank_pkg::ST_IDLE;
         reg_bank_pkg::ST_CLEAR: state_next = reg_bank_pkg::ST_IDLE;
         default: state_next = reg_bank_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         state_reg <= reg_bank_pkg::ST_IDLE;
      else if (i_ce)
         state_reg <= state_next;
   end

   // Reset request register; self-clears when the reset cycle runs
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         global_reset_reg <= reg_bank_pkg::RESET_ZERO;
      else if (i_ce)
      begin
         if (soft_rst)
            global_reset_reg <= reg_bank_pkg::RESET_ZERO;
         else if (wr_reset)
            global_reset_reg <= i_wdata & reg_bank_pkg::MASK_GLOBAL_RESET;
      end
   end

   // Reset and clear configuration; clear trigger self-clears
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         reset_config_reg <= reg_bank_pkg::RESET_ZERO;
      else if (i_ce)
      begin
         if (soft_rst)
            reset_config_reg <= reg_bank_pkg::RESET_ZERO;
         else if (wr_rcfg)
            reset_config_reg <= i_wdata & reg_bank_pkg::MASK_RESET_CONFIG;
         else if (state_reg == reg_bank_pkg::ST_CLEAR)
            reset_config_reg[reg_bank_pkg::SOFTWARE_CLEAR_BIT] <= 1'b0;
      end
   end

   // Power-off state survives the register reset
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         poc_reg <= 1'b0;
      else if (i_ce && wr_rcfg)
         poc_reg <= i_wdata[reg_bank_pkg::POWER_OFF_STATE_BIT];
   end

   // Global select, mask and response registers
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         select_reg <= reg_bank_pkg::RESET_ZERO;
         conv_select_reg <= reg_bank_pkg::RESET_ZERO;
         fault_mask_reg <= reg_bank_pkg::RESET_ZERO;
         fault_response_reg <= reg_bank_pkg::RESET_ZERO;
      end
      else if (i_ce)
      begin
         if (soft_rst)
         begin
            select_reg <= reg_bank_pkg::RESET_ZERO;
            conv_select_reg <= reg_bank_pkg::RESET_ZERO;
            fault_mask_reg <= reg_bank_pkg::RESET_ZERO;
            fault_response_reg <= reg_bank_pkg::RESET_ZERO;
         end
         else
         begin
            if (wr_sel)
               select_reg <= i_wdata & reg_bank_pkg::MASK_SELECT;
            if (wr_csel)
               conv_select_reg <= i_wdata & reg_bank_pkg::MASK_CONVERTER_SELECT;
            if (wr_mask)
               fault_mask_reg <= i_wdata & reg_bank_pkg::MASK_FAULT_MASK;
            if (wr_resp)
               fault_response_reg <= i_wdata & reg_bank_pkg::MASK_FAULT_RESPONSE;
         end
      end
   end

   // Status: hardware flags are live; echo copies the user check bit
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         status_reg <= reg_bank_pkg::RESET_ZERO;
      else if (i_ce)
      begin
         status_reg <= reg_bank_pkg::RESET_ZERO;
         status_reg[reg_bank_pkg::STATUS_CLEAR_STATE_BIT] <= clear_go;
         status_reg[reg_bank_pkg::STATUS_WATCHDOG_BIT] <= i_watchdog_timeout;
         status_reg[reg_bank_pkg::STATUS_SUPPLY_GOOD_LSB +: 4] <= i_supply_good;
         status_reg[reg_bank_pkg::STATUS_USER_ECHO_BIT] <=
            reset_config_reg[reg_bank_pkg::USER_CHECK_BIT] & ~soft_rst;
         status_reg[reg_bank_pkg::STATUS_FRAME_ERR_BIT] <= i_frame_check_error & ~soft_rst;
         status_reg[reg_bank_pkg::STATUS_THERMAL_BIT] <= i_thermal_alarm;
         status_reg[reg_bank_pkg::STATUS_LOAD_ERR_LSB +: 4] <= i_load_error;
      end
   end

   // Per-channel register copies, one set per channel
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : g_ch
         logic wr_ch;
         logic wr_cv;
         logic clr_ch;
         logic [15:0] clr_val;
         assign wr_ch = i_wr_en && ch_sel[g];
         assign wr_cv = i_wr_en && conv_sel[g];
         assign clr_ch = clear_go && clr_permit[g];
         assign clr_val = clr_level[g] ? reg_bank_pkg::CODE_MID_SCALE :
                          reg_bank_pkg::CODE_ZERO_SCALE;

         channel_store #(.WIDTH(16), .RESET_VALUE(reg_bank_pkg::RESET_ZERO)) u_cfg (
            .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_soft_rst(soft_rst),
            .i_wr(wr_ch && (i_addr == reg_bank_pkg::ADDR_CHANNEL_OUTPUT_CONFIG)),
            .i_wdata(i_wdata), .i_clr(1'b0), .i_clr_value(reg_bank_pkg::RESET_ZERO),
            .o_value(cfg_q[g]));
         channel_store #(.WIDTH(16), .RESET_VALUE(reg_bank_pkg::RESET_ZERO)) u_code (
            .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_soft_rst(soft_rst),
            .i_wr(wr_ch && (i_addr == reg_bank_pkg::ADDR_CHANNEL_OUTPUT_CODE)),
            .i_wdata(i_wdata), .i_clr(clr_ch), .i_clr_value(clr_val),
            .o_value(code_q[g]));
         channel_store #(.WIDTH(16), .RESET_VALUE(reg_bank_pkg::RESET_ZERO)) u_cconf (
            .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_soft_rst(soft_rst),
            .i_wr(wr_cv && (i_addr == reg_bank_pkg::ADDR_CONVERTER_CONFIG)),
            .i_wdata(i_wdata & reg_bank_pkg::MASK_CONVERTER_CONFIG), .i_clr(1'b0),
            .i_clr_value(reg_bank_pkg::RESET_ZERO), .o_value(cconf_q[g]));
         channel_store #(.WIDTH(16), .RESET_VALUE(reg_bank_pkg::RESET_ZERO)) u_cal (
            .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_soft_rst(soft_rst),
            .i_wr(wr_ch && (i_addr == reg_bank_pkg::ADDR_CALIBRATION_ENABLE)),
            .i_wdata(i_wdata & reg_bank_pkg::MASK_CAL_ENABLE), .i_clr(1'b0),
            .i_clr_value(reg_bank_pkg::RESET_ZERO), .o_value(cal_q[g]));
         channel_store #(.WIDTH(16), .RESET_VALUE(reg_bank_pkg::RESET_GAIN_TRIM)) u_gain (
            .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_soft_rst(soft_rst),
            .i_wr(wr_ch && (i_addr == reg_bank_pkg::ADDR_GAIN_TRIM)),
            .i_wdata(i_wdata), .i_clr(1'b0), .i_clr_value(reg_bank_pkg::RESET_ZERO),
            .o_value(gain_q[g]));
         channel_store #(.WIDTH(16), .RESET_VALUE(reg_bank_pkg::RESET_ZERO)) u_off (
            .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_soft_rst(soft_rst),
            .i_wr(wr_ch && (i_addr == reg_bank_pkg::ADDR_OFFSET_TRIM)),
            .i_wdata(i_wdata), .i_clr(1'b0), .i_clr_value(reg_bank_pkg::RESET_ZERO),
            .o_value(off_q[g]));
         channel_store #(.WIDTH(16), .RESET_VALUE(reg_bank_pkg::RESET_ZERO)) u_fcode (
            .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_soft_rst(soft_rst),
            .i_wr(wr_ch && (i_addr == reg_bank_pkg::ADDR_FAULT_OUTPUT_CODE)),
            .i_wdata(i_wdata & reg_bank_pkg::MASK_FAULT_CODE), .i_clr(1'b0),
            .i_clr_value(reg_bank_pkg::RESET_ZERO), .o_value(fcode_q[g]));

         reg_bank_pkg::gain_sel_t gsel;
         gain_decode u_gain_dec (
            .i_range(cfg_q[g][reg_bank_pkg::RANGE_LSB +: 4]),
            .o_gain(gsel),
            .o_valid(o_range_valid[g]));
         assign o_gain_sel[3*g +: 3] = gsel;
         assign o_output_code[16*g +: 16] = code_q[g];
      end
   endgenerate

   // Per-channel readback from the lowest selected channel
   always_comb
   begin
      ch_rd = reg_bank_pkg::RESET_ZERO;
      for (int k = CHANNELS - 1; k >= 0; k--)
      begin
         if (ch_sel[k])
         begin
            case (i_addr)
               reg_bank_pkg::ADDR_CHANNEL_OUTPUT_CONFIG: ch_rd = cfg_q[k];
               reg_bank_pkg::ADDR_CHANNEL_OUTPUT_CODE: ch_rd = code_q[k];
               reg_bank_pkg::ADDR_CALIBRATION_ENABLE: ch_rd = cal_q[k];
               reg_bank_pkg::ADDR_GAIN_TRIM: ch_rd = gain_q[k];
               reg_bank_pkg::ADDR_OFFSET_TRIM: ch_rd = off_q[k];
               reg_bank_pkg::ADDR_FAULT_OUTPUT_CODE: ch_rd = fcode_q[k];
               default: ch_rd = ch_rd;
            endcase
         end
         if (conv_sel[k] && (i_addr == reg_bank_pkg::ADDR_CONVERTER_CONFIG))
            ch_rd = cconf_q[k];
      end
   end

   // Read multiplexer; write-only and unmapped addresses read zero
   always_comb
   begin
      case (i_addr)
         reg_bank_pkg::ADDR_GLOBAL_RESET: rd_mux = global_reset_reg;
         reg_bank_pkg::ADDR_RESET_AND_CLEAR_CONFIG:
            rd_mux = reset_config_reg | ({15'h0000, poc_reg} << reg_bank_pkg::POWER_OFF_STATE_BIT);
         reg_bank_pkg::ADDR_CHANNEL_AND_FEATURE_SELECT: rd_mux = select_reg;
         reg_bank_pkg::ADDR_CONVERTER_SELECT: rd_mux = conv_select_reg;
         reg_bank_pkg::ADDR_FAULT_STATUS: rd_mux = status_reg;
         reg_bank_pkg::ADDR_FAULT_MASK: rd_mux = fault_mask_reg;
         reg_bank_pkg::ADDR_FAULT_RESPONSE: rd_mux = fault_response_reg;
         reg_bank_pkg::ADDR_PART_IDENTITY: rd_mux = PART_ID_CODE & reg_bank_pkg::MASK_PART_ID;
         default: rd_mux = ch_rd;
      endcase
   end

   // Registered read data and watchdog service pulse
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rdata_reg <= reg_bank_pkg::RESET_ZERO;
         rd_valid_reg <= 1'b0;
         wd_service_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         rd_valid_reg <= i_rd_en;
         wd_service_reg <= wr_wd && i_wdata[0];
         if (i_rd_en)
            rdata_reg <= rd_mux;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_rd_valid = rd_valid_reg;
   assign o_watchdog_service = wd_service_reg;
   assign o_power_off_output_state = poc_reg;
   assign o_ref_enable = reset_config_reg[reg_bank_pkg::REF_ENABLE_BIT];
   assign o_transparent_serial_mode = reset_config_reg[reg_bank_pkg::TRANSPARENT_BIT];
   assign o_serial_out_disable = select_reg[4];
   assign o_frame_check_enable = select_reg[3];
   assign o_clear_state = status_reg[reg_bank_pkg::STATUS_CLEAR_STATE_BIT];
endmodule : quad_dac_control_register_bank
`default_nettype wire

/* File: test/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port; one request at a time
module host_model (
   input wire logic i_clk,
   input wire logic i_rd_valid,
   input wire logic [15:0] i_rdata,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [7:0] o_addr,
   output logic [15:0] o_wdata
);
   // Idle bus at time zero
   initial
   begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 8'h00;
      o_wdata = 16'h0000;
   end
   // One write; address and data inverted once released
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      #1;
      o_wr_en = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(posedge i_clk);
      #1;
      o_wr_en = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask : wr
   // One read; answer expected just after the same edge that takes the request
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge i_clk);
      #1;
      o_rd_en = 1'b1;
      o_addr = a;
      @(posedge i_clk);
      #1;
      o_rd_en = 1'b0;
      o_addr = ~a;
      d = i_rd_valid ? i_rdata : 16'hxxxx;
   endtask : rd
endmodule : host_model
`default_nettype wire

/* File: test/reg_bank_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Port checks of the register bank
module reg_bank_monitor (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic [15:0] o_rdata,
   input wire logic o_rd_valid,
   input wire logic o_watchdog_service,
   input wire logic o_power_off_output_state,
   input wire logic o_ref_enable,
   input wire logic o_transparent_serial_mode,
   input wire logic o_clear_state,
   input wire logic [63:0] o_output_code,
   input wire logic [11:0] o_gain_sel,
   input wire logic [3:0] o_range_valid
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   // Decoded host requests
   wire logic wr = i_ce && i_wr_en;
   wire logic rd = i_ce && i_rd_en;
   wire logic rst_wr = wr && i_addr == 8'h01 && i_wdata[0];
   wire logic clr_wr = wr && i_addr == 8'h02 && i_wdata[2] && |i_wdata[12:9];
   // Read handshake
   chk_read_answer: assert property (rd |=> o_rd_valid)
      else $error("read not answered");
   chk_read_cause: assert property (o_rd_valid |-> $past(rd))
      else $error("read answer without request");
   chk_rdata_hold: assert property (!$past(rd) |-> $stable(o_rdata))
      else $error("read data moved without read");
   // Reset, clear and output levels
   chk_poc_keep: assert property ($changed(o_power_off_output_state) |-> $past(wr && i_addr == 8'h02))
      else $error("power-off state moved");
   chk_reset_defaults: assert property (rst_wr ##1 i_ce ##1 (i_ce && !i_wr_en) |=>
      {o_ref_enable, o_transparent_serial_mode, o_output_code} == 66'h0)
      else $error("soft reset left state");
   chk_clear_state: assert property (clr_wr ##1 (i_ce && !i_wr_en) [*2] |-> ##[0:3] o_clear_state)
      else $error("clear state not shown");
   chk_range_gain: assert property (o_range_valid[0] |-> o_gain_sel[2:0] <= 3'h5)
      else $error("gain code out of range");
   chk_service_pulse: assert property (o_watchdog_service |-> $past(wr && i_addr == 8'h10 && i_wdata[0]))
      else $error("service pulse without write");
   cover property (rst_wr);
   cover property (clr_wr);
   cover property (rd ##1 o_rd_valid);
endmodule : reg_bank_monitor
`default_nettype wire

/* File: test/test_quad_dac_control_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Compare expected and seen, count both
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; $display("wrong value %s exp %h got %h", n, e, a); end end
module test_quad_dac_control_register_bank;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic hw_clear = 1'b0;
   logic flags = 1'b1;
   logic [3:0] supply = 4'hA;
   logic [3:0] load = 4'h5;
   logic wr_en, rd_en, rd_valid, wdog, power_off_output_state, ref_en, transparent_serial_mode, clr_st, sdo_dis, crc_en;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, rd;
   logic [63:0] codes;
   logic [11:0] gain;
   logic [3:0] rv;
   int failures = 0;
   int comparisons = 0;
   // Rows: write address, write data, read address, expected read
   localparam logic [47:0] ROWS [12] = '{48'h03FF_FF03_1FFF, 48'h0512_3405_1234, 48'h09AB_CD09_ABCD,
      48'h0A80_010A_8001, 48'h0400_0B04_000B, 48'h00FF_FF00_0000, 48'h0FFF_FF0F_0000, 48'h01FF_FE01_0000,
      48'h021E_1F05_8000, 48'h021E_1F02_1E1B, 48'h0000_000B_0D75, 48'h11FF_FF11_0005};
   localparam logic [35:0] RCODES = 36'h0_1238_9AB4;
   localparam logic [35:0] GEXP = 36'h8_99AB_CCD0;
   always #10 clk = ~clk;
   quad_dac_control_register_bank dut (.i_clk(clk), .i_sys_rst(sys_rst), .i_ce(ce), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_hw_clear(hw_clear), .i_watchdog_timeout(flags),
      .i_supply_good(supply), .i_frame_check_error(flags), .i_thermal_alarm(flags), .i_load_error(load),
      .o_rdata(rdata), .o_rd_valid(rd_valid), .o_watchdog_service(wdog), .o_power_off_output_state(power_off_output_state),
      .o_ref_enable(ref_en), .o_transparent_serial_mode(transparent_serial_mode), .o_serial_out_disable(sdo_dis),
      .o_frame_check_enable(crc_en), .o_clear_state(clr_st), .o_output_code(codes), .o_gain_sel(gain),
      .o_range_valid(rv));
   host_model host (.i_clk(clk), .i_rd_valid(rd_valid), .i_rdata(rdata), .o_wr_en(wr_en), .o_rd_en(rd_en),
      .o_addr(addr), .o_wdata(wdata));
   // Print counts and verdict, then stop
   task automatic end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   // Watchdog against a hang
   initial
   begin
      #100000;
      failures++;
      end_sim();
   end
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      #1 sys_rst = 1'b0;
      `CHK("reset state", 17'h0_0000, {power_off_output_state, rdata})
      for (int k = 0; k < 12; k++)
      begin
         host.wr(ROWS[k][47:40], ROWS[k][39:24]);
         repeat (2) @(posedge clk);
         host.rd(ROWS[k][23:16], rd);
         `CHK("row read", ROWS[k][15:0], rd)
      end
      `CHK("config outs", 5'h1F, {ref_en, transparent_serial_mode, power_off_output_state, sdo_dis, crc_en})
      for (int k = 0; k < 9; k++)
      begin
         host.wr(8'h04, {12'h000, RCODES[35-4*k -: 4]});
         `CHK("gain", GEXP[35-4*k -: 4], {rv[0], gain[2:0]})
      end
      host.wr(8'h03, 16'h0060);
      host.wr(8'h05, 16'h1111);
      host.wr(8'h02, 16'h0206);
      repeat (3) @(posedge clk);
      `CHK("codes", 64'h8000_8000_1111_0000, codes)
      host.wr(8'h10, 16'h0001);
      `CHK("service", 1'b1, wdog)
      host.wr(8'h01, 16'h0001);
      repeat (3) @(posedge clk);
      host.rd(8'h01, rd);
      `CHK("reset bit", 16'h0000, rd)
      host.rd(8'h02, rd);
      `CHK("config", 16'h0002, rd)
      host.wr(8'h03, 16'h0020);
      host.rd(8'h09, rd);
      `CHK("gain trim", 16'h8000, rd)
      `CHK("after reset", 67'h4_0000_0000_0000_0000, {power_off_output_state, ref_en, transparent_serial_mode, codes})
      // Write with clock enable low is lost; hardware clear waits for its permit
      host.wr(8'h05, 16'h4321);
      ce = 1'b0;
      host.wr(8'h05, 16'h0000);
      ce = 1'b1;
      @(posedge clk) #1 hw_clear = 1'b1;
      @(posedge clk) #1 hw_clear = 1'b0;
      `CHK("frozen and blocked", 16'h4321, codes[15:0])
      host.wr(8'h02, 16'h0200);
      @(posedge clk) #1 hw_clear = 1'b1;
      @(posedge clk) #1 hw_clear = 1'b0;
      `CHK("hw clear", 17'h1_0000, {clr_st, codes[15:0]})
      end_sim();
   end
endmodule : test_quad_dac_control_register_bank
bind quad_dac_control_register_bank reg_bank_monitor mon (.i_clk, .i_sys_rst, .i_ce, .i_wr_en, .i_rd_en,
   .i_addr, .i_wdata, .o_rdata, .o_rd_valid, .o_watchdog_service, .o_power_off_output_state, .o_ref_enable,
   .o_transparent_serial_mode, .o_clear_state, .o_output_code, .o_gain_sel, .o_range_valid);
`default_nettype wire
